// [rtl/rfh_fifo_gpio.sv]
// radio data queues, serial access, pin state control and pin mapping
`timescale 1ns/1ps
`default_nettype none
`include "rfh_cfg.svh"
module rfh_fifo_gpio (
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // serial link from the host
   input wire logic link_sclk_i,
   input wire logic csn_i,
   input wire logic si_i,
   // configuration
   input wire logic pin_state_control_enable_i,
   input wire rfh_pkg::rfh_pin_cfg_s [3:0] pin_cfg_i,
   input wire logic [6:0] queue_fill_threshold_i,
   input wire logic external_sync_enable_i,
   input wire logic blind_mode_i,
   // radio side
   input wire rfh_pkg::rfh_radio_evt_s radio_evt_i,
   input wire logic crystal_off_request_i,
   input wire logic chip_ready_low_i,
   input wire logic serial_clk_i,
   output logic [7:0] tx_data_o,
   output rfh_pkg::rfh_radio_e radio_state_o,
   output rfh_pkg::rfh_err_s queue_err_o,
   output logic rx_restart_o,
   output logic modem_sync_switch_o,
   output logic serial_tx_data_o,
   output logic serial_tx_valid_o,
   output logic external_slow_clock_o,
   // general-purpose pins
   input wire logic [3:0] gpio_i,
   output logic [3:0] gpio_o,
   output logic [3:0] gpio_oe_n_o
);
   import rfh_pkg::*;

   rfh_core_s q, next_q;
   logic rst_meta, rst_n;
   logic link_so, link_done, link_start;
   logic [7:0] link_rx_byte;
   logic done_ev, start_ev, cs_fall, cs_rise;
   logic flush_tx, flush_rx, go_sleep, err_ev;
   logic rx_lvl, tx_lvl;
   logic [7:0] tx_lim;
   logic [63:0] sig;
   logic [5:0] sel;

   function automatic logic is_full(input logic [7:0] cnt);
      return cnt == `RFH_QUEUE_DEPTH;
   endfunction

   function automatic logic is_empty(input logic [7:0] cnt);
      return cnt == 8'h00;
   endfunction

   // reset release through two flops
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // link side shifter on the host clock
   rfh_spi_link u_link (
      .link_sclk_i(link_sclk_i),
      .csn_i(csn_i),
      .si_i(si_i),
      .rstn_i(rst_n),
      .tx_byte_i(q.link_byte),
      .so_o(link_so),
      .rx_byte_o(link_rx_byte),
      .done_tgl_o(link_done),
      .start_tgl_o(link_start)
   );

   // events seen after the synchronisers
   assign done_ev = q.done_s ^ q.done_d;
   assign start_ev = q.start_s ^ q.start_d;
   assign cs_fall = q.csn_d & ~q.csn_s;
   assign cs_rise = ~q.csn_d & q.csn_s;

   always_comb
   begin
      next_q = q;
      flush_tx = 1'b0;
      flush_rx = 1'b0;
      go_sleep = 1'b0;
      err_ev = 1'b0;
      sig = 64'h0000000000000000;
      sel = 6'h00;

      // two-flop synchronisers for pins and link toggles
      next_q.csn_m = csn_i;
      next_q.csn_s = q.csn_m;
      next_q.csn_d = q.csn_s;
      next_q.sclk_m = link_sclk_i;
      next_q.sclk_s = q.sclk_m;
      next_q.si_m = si_i;
      next_q.si_s = q.si_m;
      next_q.gin_m = gpio_i;
      next_q.gin_s = q.gin_m;
      next_q.gin_d = q.gin_s;
      next_q.done_m = link_done;
      next_q.done_s = q.done_m;
      next_q.done_d = q.done_s;
      next_q.start_m = link_start;
      next_q.start_s = q.start_m;
      next_q.start_d = q.start_s;

      // pulse stretchers count down, loads below override
      if (q.restart_cnt != 2'h0)
         next_q.restart_cnt = q.restart_cnt - 2'h1;
      if (q.sync_cnt != 2'h0)
         next_q.sync_cnt = q.sync_cnt - 2'h1;

      // radio writes received bytes; a full queue is an overrun
      if (radio_evt_i.rx_push)
      begin
         if (is_full(q.rx_cnt))
         begin
            next_q.err.rx_over = 1'b1;
            next_q.radio = RS_RX_ERR;
            err_ev = 1'b1;
         end
         else
         begin
            next_q.rxq[q.rx_wr] = radio_evt_i.rx_data;
            next_q.rx_wr = q.rx_wr + 7'h01;
            next_q.rx_cnt = next_q.rx_cnt + 8'h01;
         end
      end

      // radio takes bytes to send; running dry inside a packet fails
      if (radio_evt_i.tx_pop)
      begin
         if (is_empty(q.tx_cnt))
         begin
            if (radio_evt_i.tx_in_packet)
            begin
               next_q.err.tx_under = 1'b1;
               next_q.radio = RS_TX_ERR;
               err_ev = 1'b1;
            end
         end
         else
         begin
            next_q.tx_data = q.txq[q.tx_rd];
            next_q.tx_rd = q.tx_rd + 7'h01;
            next_q.tx_cnt = next_q.tx_cnt - 8'h01;
         end
      end

      // completed bytes from the link: headers, strobes, write data
      if (done_ev)
      begin
         if (q.par_hdr)
         begin
            if (link_rx_byte[5:0] == `RFH_FIFO_ADDR)
            begin
               next_q.par_hdr = 1'b0;
               next_q.par_rw = link_rx_byte[`RFH_HDR_RW];
               next_q.par_burst = link_rx_byte[`RFH_HDR_BURST];
            end
            else if (link_rx_byte[5:0] == `RFH_FLUSH_RX_ADDR)
               flush_rx = 1'b1;
            else if (link_rx_byte[5:0] == `RFH_FLUSH_TX_ADDR)
               flush_tx = 1'b1;
         end
         else
         begin
            if (!q.par_rw)
            begin
               if (is_full(q.tx_cnt))
               begin
                  next_q.err.tx_over = 1'b1;
                  next_q.radio = RS_TX_ERR;
                  err_ev = 1'b1;
               end
               else
               begin
                  next_q.txq[q.tx_wr] = link_rx_byte;
                  next_q.tx_wr = q.tx_wr + 7'h01;
                  next_q.tx_cnt = next_q.tx_cnt + 8'h01;
               end
            end
            // single access returns to header after one byte
            if (!q.par_burst)
               next_q.par_hdr = 1'b1;
         end
      end

      // a read byte is committed when its first bit goes out; the link
      // already holds it, so popping now gives the next head a full byte
      if (start_ev && !q.par_hdr && q.par_rw)
      begin
         if (is_empty(q.rx_cnt))
         begin
            next_q.err.rx_under = 1'b1;
            next_q.radio = RS_RX_ERR;
            err_ev = 1'b1;
         end
         else
         begin
            next_q.rx_rd = q.rx_rd + 7'h01;
            next_q.rx_cnt = next_q.rx_cnt - 8'h01;
         end
      end

      // deselect ends any access and releases a held power-down
      if (cs_rise)
      begin
         next_q.par_hdr = 1'b1;
         if (q.pwd_pending)
         begin
            next_q.pwd_pending = 1'b0;
            go_sleep = 1'b1;
         end
      end

      // select falling: wake up, then the latched pin pair if enabled
      if (cs_fall)
      begin
         if (q.radio == RS_SLEEP || q.radio == RS_CRYSTAL_OFF_STATE)
            next_q.radio = RS_IDLE;
         if (pin_state_control_enable_i)
         begin
            // sampled pair is the level taken in the same clock sample as the first low select
            unique case ({q.sclk_s, q.si_s})
               2'b00: next_q.pwd_pending = 1'b1;
               2'b01:
               begin
                  if (q.radio != RS_TX)
                     next_q.radio = RS_TX;
               end
               2'b10: next_q.radio = RS_IDLE;
               2'b11:
               begin
                  next_q.radio = RS_RX;
                  if (q.radio == RS_RX)
                     next_q.restart_cnt = `RFH_PULSE_PERIODS;
               end
            endcase
         end
      end

      if (crystal_off_request_i && q.radio == RS_IDLE)
         next_q.radio = RS_CRYSTAL_OFF_STATE;
      if (go_sleep)
         next_q.radio = RS_SLEEP;

      // entering sleep empties both queues and holds the low-code pins
      if (next_q.radio == RS_SLEEP && q.radio != RS_SLEEP)
      begin
         flush_tx = 1'b1;
         flush_rx = 1'b1;
         next_q.sleep_hold = 1'b1;
      end

      // flushes empty the queue and clear its sticky errors
      if (flush_rx)
      begin
         next_q.rx_wr = 7'h00;
         next_q.rx_rd = 7'h00;
         next_q.rx_cnt = 8'h00;
         next_q.err.rx_over = 1'b0;
         next_q.err.rx_under = 1'b0;
         if (q.radio == RS_RX_ERR && next_q.radio == RS_RX_ERR)
            next_q.radio = RS_IDLE;
      end
      if (flush_tx)
      begin
         next_q.tx_wr = 7'h00;
         next_q.tx_rd = 7'h00;
         next_q.tx_cnt = 8'h00;
         next_q.err.tx_over = 1'b0;
         next_q.err.tx_under = 1'b0;
         if (q.radio == RS_TX_ERR && next_q.radio == RS_TX_ERR)
            next_q.radio = RS_IDLE;
      end

      // head of the receive queue is always what the link sends next
      next_q.link_byte = next_q.rxq[next_q.rx_rd];

      // fill level flags; every set is placed after its clear
      tx_lim = `RFH_TX_LIMIT_BASE - {1'b0, queue_fill_threshold_i};
      rx_lvl = next_q.rx_cnt > {1'b0, queue_fill_threshold_i};
      tx_lvl = next_q.tx_cnt >= tx_lim;
      if (is_empty(next_q.rx_cnt))
         next_q.rx_thr_pkt = 1'b0;
      if (rx_lvl || (radio_evt_i.packet_end && q.radio == RS_RX))
         next_q.rx_thr_pkt = 1'b1;
      if (next_q.tx_cnt < tx_lim)
         next_q.tx_full_flag = 1'b0;
      if (is_full(next_q.tx_cnt))
         next_q.tx_full_flag = 1'b1;
      if (radio_evt_i.packet_end || err_ev ||
          (radio_evt_i.check_fail && q.radio == RS_RX))
         next_q.pkt_flag = 1'b0;
      if (radio_evt_i.sync_found)
         next_q.pkt_flag = 1'b1;

      // pin forcing lasts until the ready signal falls outside sleep
      next_q.crdy_d = chip_ready_low_i;
      if (q.crdy_d && !chip_ready_low_i && q.radio != RS_SLEEP)
         next_q.sleep_hold = 1'b0;

      // signals a pin may carry, indexed by selection code
      sig[`RFH_SEL_RX_LEVEL] = rx_lvl;
      sig[`RFH_SEL_RX_PKT] = next_q.rx_thr_pkt;
      sig[`RFH_SEL_TX_LEVEL] = tx_lvl;
      sig[`RFH_SEL_TX_FULL] = next_q.tx_full_flag;
      sig[`RFH_SEL_RX_OVERRUN] = next_q.err.rx_over;
      sig[`RFH_SEL_TX_UNDERRUN] = next_q.err.tx_under;
      sig[`RFH_SEL_PKT_ACTIVE] = next_q.pkt_flag;
      sig[`RFH_SEL_CHECKSUM] = radio_evt_i.checksum_good;
      sig[`RFH_SEL_CHIP_READY] = chip_ready_low_i;

      // output mapping; in sleep low codes are forced per pin parity
      for (int i = 0; i < 4; i++)
      begin
         sel = pin_cfg_i[i].sel;
         next_q.gpio_out[i] = sig[sel] ^ pin_cfg_i[i].inv;
         if (next_q.sleep_hold && sel < `RFH_SEL_SLEEP_LIMIT)
            next_q.gpio_out[i] = pin_cfg_i[i].inv ^ i[0];
         next_q.gpio_oe_n[i] = (sel == `RFH_SEL_TRISTATE);
      end

      // pin 0 as serial transmit data, taken on the serial clock rise
      next_q.ser_clk_d = serial_clk_i;
      next_q.ser_valid = 1'b0;
      if (pin_cfg_i[0].sel == `RFH_SEL_TRISTATE &&
          serial_clk_i && !q.ser_clk_d)
      begin
         next_q.ser_bit = q.gin_s[0];
         next_q.ser_valid = 1'b1;
      end

      // pin 2 rising in blind mode switches the modem to packet receive
      if (pin_cfg_i[2].sel == `RFH_SEL_TRISTATE && external_sync_enable_i &&
          blind_mode_i && q.gin_s[2] && !q.gin_d[2])
         next_q.sync_cnt = `RFH_PULSE_PERIODS;

      // pin 3 carries an external slow clock when it is an input
      next_q.slow_clk = (pin_cfg_i[3].sel == `RFH_SEL_TRISTATE) &&
                        q.gin_s[3];
   end

   // single state register; pins start released and select idle high
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.csn_m <= 1'b1;
         q.csn_s <= 1'b1;
         q.csn_d <= 1'b1;
         q.par_hdr <= 1'b1;
         q.gpio_oe_n <= 4'hF;
      end
      else
         q <= next_q;
   end

   // shared pin is serial output while selected, the mapped pin otherwise
   always_comb
   begin
      gpio_o = q.gpio_out;
      gpio_oe_n_o = q.gpio_oe_n;
      if (!q.csn_s)
      begin
         gpio_o[1] = link_so;
         gpio_oe_n_o[1] = 1'b0;
      end
   end

   // radio-facing outputs
   assign tx_data_o = q.tx_data;
   assign radio_state_o = q.radio;
   assign queue_err_o = q.err;
   assign rx_restart_o = (q.restart_cnt != 2'h0);
   assign modem_sync_switch_o = (q.sync_cnt != 2'h0);
   assign serial_tx_data_o = q.ser_bit;
   assign serial_tx_valid_o = q.ser_valid;
   assign external_slow_clock_o = q.slow_clk;

endmodule
`default_nettype wire

// [inc/rfh_cfg.svh]
// constants for the radio fifo and general-purpose pin block
`ifndef RFH_CFG_SVH
`define RFH_CFG_SVH

// header byte layout
`define RFH_HDR_RW 7
`define RFH_HDR_BURST 6
`define RFH_FIFO_ADDR 6'h3F
`define RFH_FLUSH_RX_ADDR 6'h3A
`define RFH_FLUSH_TX_ADDR 6'h3B

// queue geometry and thresholds
`define RFH_QUEUE_DEPTH 8'h80
`define RFH_TX_LIMIT_BASE 8'h7F

// pin selection codes
`define RFH_SEL_RX_LEVEL 6'h00
`define RFH_SEL_RX_PKT 6'h01
`define RFH_SEL_TX_LEVEL 6'h02
`define RFH_SEL_TX_FULL 6'h03
`define RFH_SEL_RX_OVERRUN 6'h04
`define RFH_SEL_TX_UNDERRUN 6'h05
`define RFH_SEL_PKT_ACTIVE 6'h06
`define RFH_SEL_CHECKSUM 6'h07
`define RFH_SEL_SLEEP_LIMIT 6'h30
`define RFH_SEL_TRISTATE 6'h30
`define RFH_SEL_CHIP_READY 6'h32

// status pulses last two crystal periods
`define RFH_PULSE_PERIODS 2'h2

`endif

// [inc/rfh_pkg.sv]
// types shared by the radio fifo and general-purpose pin block
package rfh_pkg;

   typedef enum logic [2:0] {
      RS_IDLE,
      RS_RX,
      RS_TX,
      RS_RX_ERR,
      RS_TX_ERR,
      RS_SLEEP,
      RS_CRYSTAL_OFF_STATE
   } rfh_radio_e;

   typedef struct packed {
      logic [5:0] sel;
      logic inv;
   } rfh_pin_cfg_s;

   typedef struct packed {
      logic rx_push;
      logic [7:0] rx_data;
      logic tx_pop;
      logic tx_in_packet;
      logic sync_found;
      logic packet_end;
      logic check_fail;
      logic checksum_good;
   } rfh_radio_evt_s;

   typedef struct packed {
      logic tx_over;
      logic tx_under;
      logic rx_over;
      logic rx_under;
   } rfh_err_s;

   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] sh;
      logic [7:0] txsh;
   } rfh_link_frame_s;

   typedef struct packed {
      logic [7:0] rx_byte;
      logic done_tgl;
      logic start_tgl;
   } rfh_link_evt_s;

   typedef struct packed {
      logic csn_m, csn_s, csn_d;
      logic sclk_m, sclk_s;
      logic si_m, si_s;
      logic [3:0] gin_m, gin_s, gin_d;
      logic done_m, done_s, done_d;
      logic start_m, start_s, start_d;
      rfh_radio_e radio;
      logic pwd_pending;
      logic par_hdr, par_rw, par_burst;
      logic [127:0][7:0] txq;
      logic [127:0][7:0] rxq;
      logic [6:0] tx_wr, tx_rd, rx_wr, rx_rd;
      logic [7:0] tx_cnt, rx_cnt;
      rfh_err_s err;
      logic rx_thr_pkt, tx_full_flag, pkt_flag;
      logic sleep_hold, crdy_d, ser_clk_d;
      logic [7:0] link_byte, tx_data;
      logic [1:0] restart_cnt, sync_cnt;
      logic [3:0] gpio_out, gpio_oe_n;
      logic ser_bit, ser_valid, slow_clk;
   } rfh_core_s;

endpackage

// [rtl/rfh_spi_link.sv]
// serial link shifter running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module rfh_spi_link (
   // link pins
   input wire logic link_sclk_i,
   input wire logic csn_i,
   input wire logic si_i,
   // reset from the core domain
   input wire logic rstn_i,
   // byte to send, held stable by the core
   input wire logic [7:0] tx_byte_i,
   // serial output and received bytes
   output logic so_o,
   output logic [7:0] rx_byte_o,
   output logic done_tgl_o,
   output logic start_tgl_o
);
   import rfh_pkg::*;

   rfh_link_frame_s f, next_f;
   rfh_link_evt_s e, next_e;

   // bit counter and shifters; the next byte to send is taken at the
   // last bit of the current one, so the core has a whole byte to refill
   always_comb
   begin
      next_f = f;
      next_f.cnt = f.cnt + 3'h1;
      next_f.sh = {f.sh[5:0], si_i};
      if (f.cnt == 3'h7)
      begin
         next_f.txsh = tx_byte_i;
      end
   end

   // the frame state ends with the frame: chip select high clears it
   always_ff @(posedge link_sclk_i or posedge csn_i)
   begin
      if (csn_i)
         f <= '0;
      else
         f <= next_f;
   end

   // toggles tell the core that a byte has started or finished
   always_comb
   begin
      next_e = e;
      if (!csn_i && f.cnt == 3'h0)
      begin
         next_e.start_tgl = ~e.start_tgl;
      end
      if (!csn_i && f.cnt == 3'h7)
      begin
         next_e.rx_byte = {f.sh, si_i};
         next_e.done_tgl = ~e.done_tgl;
      end
   end

   // toggles must survive chip select, so only the core reset clears them
   always_ff @(posedge link_sclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         e <= '0;
      else
         e <= next_e;
   end

   // data changes on the falling edge, msb first
   always_ff @(negedge link_sclk_i or posedge csn_i)
   begin
      if (csn_i)
         so_o <= 1'b0;
      else
         so_o <= f.txsh[3'h7 - f.cnt];
   end

   assign rx_byte_o = e.rx_byte;
   assign done_tgl_o = e.done_tgl;
   assign start_tgl_o = e.start_tgl;

endmodule
`default_nettype wire

// [test/rfh_fifo_gpio_asserts.sv]
// assertions on the ports of the radio fifo and pin block
`timescale 1ns/1ps
`default_nettype none
module rfh_fifo_gpio_asserts
   import rfh_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // watched pins
   input wire logic csn_i,
   input wire rfh_pkg::rfh_pin_cfg_s [3:0] pin_cfg_i,
   input wire rfh_pkg::rfh_radio_e radio_state_o,
   input wire rfh_pkg::rfh_err_s queue_err_o,
   input wire logic rx_restart_o,
   input wire logic modem_sync_switch_o,
   input wire logic [3:0] gpio_o,
   input wire logic [3:0] gpio_oe_n_o
);
   default clocking dc @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   // a queue error lands the radio in the matching error state unless another state write in the same cycle overrides it
   property p_rx_err;
      $rose(queue_err_o.rx_over) || $rose(queue_err_o.rx_under)
         |-> ##[0:1] radio_state_o == RS_RX_ERR;
   endproperty
   a_rx_err: assert property (p_rx_err)
      else $error("rx queue error without rx error state");
   property p_tx_err;
      $rose(queue_err_o.tx_over) || $rose(queue_err_o.tx_under)
         |-> ##[0:1] radio_state_o == RS_TX_ERR;
   endproperty
   a_tx_err: assert property (p_tx_err)
      else $error("tx queue error without tx error state");
   // pulses are exactly two clocks wide
   property p_restart;
      $rose(rx_restart_o) |=> rx_restart_o ##1 !rx_restart_o;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart pulse width wrong");
   property p_sync;
      $rose(modem_sync_switch_o) |=> modem_sync_switch_o ##1
         !modem_sync_switch_o;
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync switch pulse width wrong");
   // sleep only once select has been high a while
   property p_pwd;
      $rose(radio_state_o == RS_SLEEP) |-> $past(csn_i, 2) && csn_i;
   endproperty
   a_pwd: assert property (p_pwd)
      else $error("sleep entered while selected");
   property p_wake;
      $fell(csn_i) && (radio_state_o == RS_SLEEP ||
         radio_state_o == RS_CRYSTAL_OFF_STATE) |-> ##[2:5] radio_state_o == RS_IDLE;
   endproperty
   a_wake: assert property (p_wake)
      else $error("select fall did not wake to idle");
   // shared pin drives serial output only while selected
   property p_so_on;
      $fell(csn_i) |-> ##[2:4] !gpio_oe_n_o[1];
   endproperty
   a_so_on: assert property (p_so_on)
      else $error("serial output not driven");
   property p_so_off;
      csn_i [*5] ##0 pin_cfg_i[1].sel == 6'h30 |=> gpio_oe_n_o[1];
   endproperty
   a_so_off: assert property (p_so_off)
      else $error("shared pin driven while deselected");
   property p_tristate;
      pin_cfg_i[0].sel == 6'h30 |=> gpio_oe_n_o[0];
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("tristate pin is driven");
   // guard skips the two clocks of internal reset after release
   property p_drive;
      rstn_i [*5] ##0 pin_cfg_i[2].sel != 6'h30 |=> !gpio_oe_n_o[2];
   endproperty
   a_drive: assert property (p_drive)
      else $error("output pin not driven");
   property p_over_pin;
      $rose(queue_err_o.rx_over) && pin_cfg_i[3] == 7'h08
         |-> ##[0:1] gpio_o[3];
   endproperty
   a_over_pin: assert property (p_over_pin)
      else $error("overrun not shown on pin");
endmodule

bind rfh_fifo_gpio rfh_fifo_gpio_asserts chk (.clock_i, .rstn_i, .csn_i,
   .pin_cfg_i, .radio_state_o, .queue_err_o, .rx_restart_o,
   .modem_sync_switch_o, .gpio_o, .gpio_oe_n_o);
`default_nettype wire

// [test/rfh_host_model.sv]
// host serial master driving the block's link pins
`timescale 1ns/1ps
`default_nettype none
module rfh_host_model (
   // link pins
   output logic sclk_o,
   output logic csn_o,
   output logic si_o,
   input wire logic so_i
);
   // idle link: deselected, clock parked low
   initial
   begin
      sclk_o = 1'b0;
      csn_o = 1'b1;
      si_o = 1'b0;
   end
   // one byte msb first; data shifts after each fall
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         si_o = tx[i];
         #62.5 sclk_o = 1'b1;
         rx[i] = so_i;
         #62.5 sclk_o = 1'b0;
      end
   endtask
   task automatic open_frame();
      csn_o = 1'b0;
      #62.5;
   endtask
   // deselect ends a burst; data line must not keep its last bit
   task automatic close_frame();
      #62.5 csn_o = 1'b1;
      si_o = ~si_o;
      #125;
   endtask
   // levels set while deselected, latched at select fall
   task automatic pin_cmd(input logic c, input logic d);
      sclk_o = c;
      si_o = d;
      #100 csn_o = 1'b0;
      #250 csn_o = 1'b1;
      #25 sclk_o = 1'b0;
      #150;
   endtask
endmodule
`default_nettype wire

// [test/rfh_fifo_gpio_bench.sv]
// self-checking bench for the radio fifo and pin block
`timescale 1ns/1ps
`default_nettype none
module rfh_fifo_gpio_bench;
   import rfh_pkg::*;
   typedef struct packed {logic [1:0] cd; rfh_radio_e st; logic rs;} rfh_row_s;
   // pin pair in, state and restart count out
   rfh_row_s rows [7] = '{{2'b11, RS_RX, 1'b0}, {2'b11, RS_RX, 1'b1},
      {2'b01, RS_TX, 1'b0}, {2'b01, RS_TX, 1'b0}, {2'b10, RS_IDLE, 1'b0},
      {2'b00, RS_SLEEP, 1'b0}, {2'b10, RS_IDLE, 1'b0}};
   logic clk, rstn, pen, esync, blind, crdy, sck2, rst_o, sync_o;
   logic sdat, sval, slow, crystal_off_state;
   logic [6:0] thr;
   logic [3:0] gin, gout, goe_n;
   logic [7:0] txd, rd;
   rfh_pin_cfg_s [3:0] cfg;
   rfh_radio_evt_s evt;
   rfh_radio_e st;
   rfh_err_s qe;
   wire sclk, csn, si;
   wire [3:0] pin_w;
   int err_total = 0, check_count = 0, nrst = 0, nsync = 0, n0;
   // pin level from whoever drives it
   assign pin_w = (goe_n & gin) | (~goe_n & gout);
   rfh_fifo_gpio uut (.clock_i(clk), .rstn_i(rstn), .link_sclk_i(sclk),
      .csn_i(csn), .si_i(si), .pin_state_control_enable_i(pen),
      .pin_cfg_i(cfg), .queue_fill_threshold_i(thr),
      .external_sync_enable_i(esync), .blind_mode_i(blind),
      .radio_evt_i(evt), .crystal_off_request_i(crystal_off_state),
      .chip_ready_low_i(crdy), .serial_clk_i(sck2), .tx_data_o(txd),
      .radio_state_o(st), .queue_err_o(qe), .rx_restart_o(rst_o),
      .modem_sync_switch_o(sync_o), .serial_tx_data_o(sdat),
      .serial_tx_valid_o(sval), .external_slow_clock_o(slow),
      .gpio_i(pin_w), .gpio_o(gout), .gpio_oe_n_o(goe_n));
   rfh_host_model host (.sclk_o(sclk), .csn_o(csn), .si_o(si),
      .so_i(pin_w[1]));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // pulse counters
   always @(posedge rst_o) nrst++;
   always @(posedge sync_o) nsync++;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic frame(input logic [7:0] h, input logic [7:0] d, int n);
      host.open_frame();
      host.xfer(h, rd);
      repeat (n) host.xfer(d, rd);
      host.close_frame();
      tick(6);
   endtask
   // one-cycle radio event
   task automatic radio(input rfh_radio_evt_s e);
      evt = e;
      tick(1);
      evt = '0;
      tick(2);
   endtask
   // cut a hang short
   initial
   begin
      #2000000;
      err_total++;
      test_done();
   end
   initial
   begin
      rstn = 1'b0;
      {pen, esync, blind, crdy, sck2, crystal_off_state} = '0;
      thr = 7'h0A;
      gin = 4'h0;
      cfg = {4{7'h60}};
      evt = '0;
      tick(12);
      rstn = 1'b1;
      tick(6);
      pen = 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         n0 = nrst;
         host.pin_cmd(rows[i].cd[1], rows[i].cd[0]);
         check(st, rows[i].st);
         check(nrst - n0, rows[i].rs);
      end
      pen = 1'b0;
      // the power-down row left the pins forced; ready falling frees them
      crdy = 1'b1;
      tick(2);
      crdy = 1'b0;
      $display("test state commands done");
      // tx queue: levels, full, overrun, flush
      cfg = {7'h0A, 7'h06, 7'h60, 7'h04};
      frame(8'h7F, 8'h5A, 116);
      check(gout[0], 1'b0);
      frame(8'h3F, 8'hA5, 1);
      check(gout[0], 1'b1);
      check(gout[2], 1'b0);
      frame(8'h7F, 8'h5A, 11);
      check(gout[2], 1'b1);
      frame(8'h3F, 8'h11, 1);
      check(qe, 4'h8);
      frame(8'h3B, 8'h00, 0);
      check(st, RS_IDLE);
      check({qe, gout[2]}, 5'h00);
      frame(8'h3F, 8'hA5, 1);
      radio(15'h0020);
      check(txd, 8'hA5);
      radio(15'h0030);
      check({qe, gout[3]}, 5'h09);
      frame(8'h3B, 8'h00, 0);
      check({qe, gout[3]}, 5'h00);
      $display("test tx queue done");
      // rx queue: levels, reads, underrun, overrun
      cfg = {7'h08, 7'h02, 7'h60, 7'h00};
      thr = 7'h01;
      for (int k = 1; k < 4; k++)
         radio({1'b1, 8'h30 + 8'(k), 6'h00});
      check(gout[2:0], 3'h5);
      frame(8'hFF, 8'h00, 2);
      check(rd, 8'h32);
      check(gout[2:0], 3'h4);
      frame(8'hBF, 8'h00, 1);
      check(rd, 8'h33);
      check(gout[2], 1'b0);
      frame(8'hBF, 8'h00, 1);
      check({qe, st}, {4'h1, RS_RX_ERR});
      frame(8'hBA, 8'h00, 0);
      check({qe, st}, {4'h0, RS_IDLE});
      repeat (129) radio({1'b1, 8'h77, 6'h00});
      check({qe, gout[3]}, 5'h05);
      frame(8'h3A, 8'h00, 0);
      // code 6 on pin 3: sync sets, packet end clears
      cfg[3] = 7'h0C;
      radio(15'h0008);
      check(gout[3], 1'b1);
      radio(15'h0004);
      check(gout[3], 1'b0);
      $display("test rx queue done");
      // pins as inputs
      cfg = {4{7'h60}};
      {esync, blind} = 2'b11;
      gin = 4'h1;
      tick(4);
      sck2 = 1'b1;
      tick(1);
      check(sval, 1'b1);
      tick(3);
      check(sdat, 1'b1);
      gin = 4'hD;
      tick(8);
      check({slow, nsync[1:0]}, 3'h5);
      check(goe_n, 4'hF);
      $display("test pin inputs done");
      // sleep forcing and queue emptying
      cfg = {7'h08, 7'h04, 7'h60, 7'h00};
      thr = 7'h7F;
      radio({1'b1, 8'h44, 6'h00});
      crdy = 1'b1;
      pen = 1'b1;
      host.pin_cmd(1'b0, 1'b0);
      check(st, RS_SLEEP);
      check({gout[3], gout[2]}, 2'h2);
      host.pin_cmd(1'b1, 1'b0);
      pen = 1'b0;
      crdy = 1'b0;
      tick(4);
      check(gout[2], 1'b1);
      // crystal off from idle, then a bare select fall wakes it
      crystal_off_state = 1'b1;
      tick(1);
      crystal_off_state = 1'b0;
      tick(1);
      check(st, RS_CRYSTAL_OFF_STATE);
      host.open_frame();
      host.close_frame();
      check(st, RS_IDLE);
      frame(8'hBF, 8'h00, 1);
      check(qe.rx_under, 1'b1);
      $display("test sleep done");
      // mid-run reset returns outputs to rest
      rstn = 1'b0;
      tick(2);
      check({goe_n, gout, qe}, 12'hF00);
      check(st, RS_IDLE);
      $display("test reset done");
      test_done();
   end
endmodule
`default_nettype wire
